// File: bench/dct_link_properties.sv
`timescale 1ns/100ps
`default_nettype none
module dct_link_properties
	import dct_pkg::*;
(
	input wire logic       sys_clk_i,
	input wire logic       arst_n_i,
	input wire dct_cmd_t   cmd,
	input wire logic [2:0] bank,
	input wire logic       cke,
	input wire logic       rst_n,
	input wire logic       auto_pre_o,
	input wire logic [2:0] auto_pre_bank_o,
	input wire logic       violation_o
);
	logic [11:0] ref_gap_q;
	logic [11:0] pdx_gap_q;
	logic [11:0] act_age_q [8];
	logic        ref_seen_q;
	logic        all_ras_ok;

	// Saturating cycle age, restarted by its event
	function automatic logic [11:0] age(input logic hit, input logic [11:0] a);
		return hit ? 12'h1 : a + 12'(a != 12'hfff);
	endfunction : age

	always_comb begin
		all_ras_ok = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (act_age_q[i] < 12'(RAS_CYC)) begin
				all_ras_ok = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ref_gap_q <= '1;
			pdx_gap_q <= '1;
			ref_seen_q <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				act_age_q[i] <= '1;
			end
		end else begin
			ref_gap_q <= age(cmd == CMD_REF, ref_gap_q);
			pdx_gap_q <= age(cmd == CMD_PDX, pdx_gap_q);
			ref_seen_q <= ref_seen_q | (cmd == CMD_REF);
			for (int i = 0; i < 8; i++) begin
				act_age_q[i] <= age(cmd == CMD_ACT && bank == 3'(i), act_age_q[i]);
			end
		end
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	reset_holds_cke_a: assert property (!rst_n |-> !cke)
		else $error("clock enable high during memory reset");
	ref_spacing_a: assert property (cmd == CMD_REF |-> ref_gap_q > 12'(RFC_CYC))
		else $error("refresh too soon after refresh");
	ref_interval_a: assert property (ref_seen_q |-> ref_gap_q <= 12'(REF_85_CYC + 32))
		else $error("refresh interval too long");
	pde_after_ref_a: assert property (cmd == CMD_PDE |-> ref_gap_q >= 12'(REFPDEN_CK))
		else $error("power-down too soon after refresh");
	dll_cmd_wait_a: assert property (cmd inside {CMD_RD, CMD_RDA, CMD_ODT}
		|-> pdx_gap_q >= 12'(XPDLL_CYC))
		else $error("locked-loop command too soon after power-down exit");
	pre_after_ras_a: assert property (cmd == CMD_PRE |-> act_age_q[bank] >= 12'(RAS_CYC))
		else $error("precharge before row active minimum");
	prea_after_ras_a: assert property (cmd == CMD_PREA |-> all_ras_ok)
		else $error("precharge all before row active minimum");
	auto_pre_ras_a: assert property (auto_pre_o
		|-> act_age_q[auto_pre_bank_o] >= 12'(RAS_CYC))
		else $error("internal precharge before row active minimum");
	no_violation_a: assert property (!violation_o)
		else $error("device flagged a timing violation");
endmodule : dct_link_properties
`default_nettype wire

// File: bench/tb_ddr3_command_timing_rules.sv
`timescale 1ns/100ps
`default_nettype none
module tb_ddr3_command_timing_rules
	import dct_pkg::*;
;
	logic        sys_clk   = 1'b0;
	logic        arst_n    = 1'b0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic        dll_off   = 1'b0;
	logic        bc4_fix   = 1'b0;
	logic [3:0]  reg_addr  = '0;
	logic [3:0]  rl        = 4'h9;
	logic [3:0]  al        = 4'h0;
	logic [3:0]  wl        = 4'h9;
	logic [31:0] reg_wdata = '0;
	logic [31:0] rnd       = 32'h1ddb;
	logic [31:0] reg_rdata;
	logic        rd_win, ap, wrs, viol;
	logic [2:0]  ap_bank;
	int          fails = 0, samples_checked = 0, cyc = 0, t0 = 0, n, e;
	dct_link_if  link ();

	dct_ctl #(.RESET_HOLD(8)) dct_ctl_inst (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .link(link.ctl));
	dct_dev dct_dev_inst (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .link(link.dev),
		.dll_off_i(dll_off), .bc4_fixed_i(bc4_fix), .read_latency_i(rl),
		.additive_latency_i(al), .write_latency_i(wl), .rd_window_o(rd_win),
		.auto_pre_o(ap), .auto_pre_bank_o(ap_bank), .wr_rec_start_o(wrs), .violation_o(viol));
	dct_link_properties dct_link_properties_inst (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
		.cmd(link.cmd), .bank(link.bank), .cke(link.cke), .rst_n(link.rst_n),
		.auto_pre_o(ap), .auto_pre_bank_o(ap_bank), .violation_o(viol));

	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] r;
		r = s ^ (s << 13);
		r = r ^ (r >> 17);
		return r ^ (r << 5);
	endfunction : xs

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
		samples_checked++;
		if (s !== x) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, x, s);
		end
	endtask : chk

	// Settled view of the cycle just started
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask : tick

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] x,
		input logic [31:0] m);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, x, reg_rdata & m);
	endtask : rd_chk

	task automatic order(input dct_cmd_t c, input logic [2:0] b, input logic bc);
		int k;
		wr(REG_CMD, {24'h0, bc, b, c});
		for (k = 0; k < 2000 && link.cmd !== c; k++) tick();
		t0 = cyc;
		chk("issue", 32'h0, 32'(k >= 2000));
	endtask : order

	task automatic lag(input string nm, input int sel, input int x);
		int k;
		logic p;
		p = 1'b0;
		for (k = 0; k < 64 && p !== 1'b1; k++) begin
			tick();
			p = sel == 0 ? wrs : sel == 1 ? rd_win : ap;
		end
		if (x >= 0) chk(nm, 32'(x), 32'(cyc - t0));
	endtask : lag

	initial begin
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd_chk("lat_reset", REG_LAT, 32'(LAT_RESET), '1);
		rd_chk("ctrl_reset", REG_CTRL, 32'(CTRL_RESET), '1);
		rd_chk("unmapped", 4'h2, 32'h0, '1);
		repeat (12) tick();
		rd_chk("init_done", REG_STATUS, 32'h2, 32'h2);
		$display("reset phase done");
		for (int i = 0; i < 4; i++) begin
			rnd = xs(rnd);
			rl <= 4'h5 + 4'(rnd[2:0]);
			al <= 4'(rnd[4:3]);
			wl <= 4'h5 + 4'(rnd[7:5]);
			dll_off <= 1'b1;
			bc4_fix <= rnd[8];
			tick();
			wr(REG_LAT, {20'h0, wl, al, rl});
			wr(REG_CTRL, {30'h0, bc4_fix, 1'b1});
			order(CMD_ACT, 3'(i), 1'b0);
			order(CMD_WR, 3'(i), rnd[9]);
			lag("wr_rec", 0, bc4_fix ? wl + 2 : wl + 4);
			order(CMD_RD, 3'(i), 1'b0);
			lag("rd_window", 1, rl + al - 1);
			order(CMD_RDA, 3'(i), 1'b0);
			lag("auto_pre", 2, -1);
			chk("auto_pre_bank", 32'(i), 32'(ap_bank));
			order(CMD_ACT, 3'(i), 1'b0);
			e = t0;
			order(CMD_PRE, 3'(i), 1'b0);
			chk("ras_hold", 32'h1, 32'(t0 - e >= RAS_CYC));
		end
		order(CMD_ACT, 3'h5, 1'b0);
		order(CMD_WRA, 3'h5, 1'b1);
		lag("auto_pre_wra", 2, -1);
		chk("auto_pre_bank_wra", 32'h5, 32'(ap_bank));
		order(CMD_REF, 3'h0, 1'b0);
		e = t0;
		order(CMD_ODT, 3'h0, 1'b0);
		chk("ref_hold", 32'h1, 32'(t0 - e > RFC_CYC));
		order(CMD_PDE, 3'h0, 1'b0);
		order(CMD_PDX, 3'h0, 1'b0);
		e = t0;
		order(CMD_RD, 3'h0, 1'b0);
		chk("dll_wait", 32'h1, 32'(t0 - e >= XPDLL_CYC));
		$display("latency phase done");
		dll_off <= 1'b0;
		bc4_fix <= 1'b0;
		for (int t = 1; t < 4; t++) begin
			wr(REG_CTRL, 32'(t << 2));
			for (n = 0; n < 800 && link.cmd !== CMD_REF; n++) tick();
			n = 0;
			repeat (2400) begin
				tick();
				if (link.cmd === CMD_REF) n++;
			end
			e = 2400 / (t == 1 ? REF_105_CYC : REF_HOT_CYC);
			chk("ref_count", 32'h1, 32'(n >= e - 1 && n <= e + 1));
		end
		$display("refresh phase done");
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		finish_test();
	end
endmodule : tb_ddr3_command_timing_rules
`default_nettype wire

// File: logic/dct_ctl.sv
`timescale 1ns/100ps
`default_nettype none
module dct_ctl
	import dct_pkg::*;
#(
	parameter int unsigned RESET_HOLD = RESET_HOLD_CYC
) (
	input  wire logic        sys_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic [31:0]      reg_rdata_o,
	dct_link_if.ctl          link
);
	typedef enum logic [2:0] {
		ST_INIT    = 3'b000,
		ST_RUN     = 3'b001,
		ST_PREALL  = 3'b010,
		ST_REFRESH = 3'b011,
		ST_POSTPRE = 3'b100
	} dct_st_t;

	typedef struct packed {
		dct_st_t         st;
		logic [31:0]     init_cnt;
		logic [11:0]     ref_cnt;
		logic            ref_due;
		logic [7:0]      rfc_cnt;
		logic [3:0]      xpdll_cnt;
		logic [3:0]      pden_cnt;
		logic [7:0][7:0] ras_cnt;
		logic [7:0][7:0] wr_cnt;
		logic            pend;
		dct_cmd_t        pcmd;
		logic [2:0]      pbank;
		logic            pbc4;
		logic [3:0]      ctrl;
		logic [11:0]     lat;
		logic [15:0]     ref_total;
		logic [31:0]     rdata;
		dct_cmd_t        cmd;
		logic [2:0]      bank;
		logic            bc4;
		logic            cke;
		logic            rst_n;
	} dct_ctl_st_t;

	dct_ctl_st_t q, d;
	logic        idle_banks;
	logic        may_issue;
	logic [11:0] ref_period;
	logic [7:0]  wr_total;

	always_comb begin
		unique case (q.ctrl[CTRL_TEMP_LO +: 2])
			2'b00:   ref_period = 12'(REF_85_CYC);
			2'b01:   ref_period = 12'(REF_105_CYC);
			default: ref_period = 12'(REF_HOT_CYC);
		endcase
	end

	assign idle_banks = (q.ras_cnt == '0) && (q.wr_cnt == '0);

	// Per-command readiness of the pending request
	always_comb begin
		may_issue = 1'b0;
		if (q.pend && q.st == ST_RUN && !q.ref_due) begin
			if (!q.cke) begin
				may_issue = (q.pcmd == CMD_PDX) && q.rfc_cnt == 8'h00;
			end else begin
				unique case (q.pcmd)
					CMD_PRE:  may_issue = q.ras_cnt[q.pbank] == 8'h00 &&
						q.wr_cnt[q.pbank] == 8'h00 && q.rfc_cnt == 8'h00;
					CMD_PREA: may_issue = idle_banks && q.rfc_cnt == 8'h00;
					CMD_REF:  may_issue = idle_banks && q.rfc_cnt == 8'h00;
					CMD_RD, CMD_RDA, CMD_ODT: begin
						may_issue = q.xpdll_cnt == 4'h0 && q.rfc_cnt == 8'h00;
					end
					CMD_PDE:  may_issue = q.pden_cnt == 4'h0 && q.xpdll_cnt == 4'h0;
					CMD_PDX:  may_issue = 1'b0;
					default:  may_issue = q.rfc_cnt == 8'h00;
				endcase
			end
		end
	end

	// Write recovery window: start offset plus recovery time
	assign wr_total = 8'(q.lat[LAT_WL_LO +: 4]) +
		(q.ctrl[CTRL_BC4_FIX] ? 8'(WREC_BC4_CK) : 8'(WREC_BL8_CK)) +
		(q.ctrl[CTRL_DLL_OFF] ? 8'(WR_OFF_CYC) : 8'(WR_CYC));

	always_comb begin
		d = q;
		d.cmd = CMD_NOP;
		d.bank = 3'h0;
		d.bc4 = 1'b0;
		d.rdata = 32'h0;
		for (int b = 0; b < 8; b++) begin
			if (q.ras_cnt[b] != 8'h00) begin
				d.ras_cnt[b] = q.ras_cnt[b] - 8'h01;
			end
			if (q.wr_cnt[b] != 8'h00) begin
				d.wr_cnt[b] = q.wr_cnt[b] - 8'h01;
			end
		end
		if (q.rfc_cnt != 8'h00) begin
			d.rfc_cnt = q.rfc_cnt - 8'h01;
		end
		if (q.xpdll_cnt != 4'h0) begin
			d.xpdll_cnt = q.xpdll_cnt - 4'h1;
		end
		if (q.pden_cnt != 4'h0) begin
			d.pden_cnt = q.pden_cnt - 4'h1;
		end
		// Interval timer raises one refresh request per temperature-selected period
		if (q.st != ST_INIT) begin
			if (q.ref_cnt >= ref_period - 12'h001) begin
				d.ref_cnt = 12'h000;
				d.ref_due = 1'b1;
			end else begin
				d.ref_cnt = q.ref_cnt + 12'h001;
			end
		end
		unique case (q.st)
			ST_INIT: begin
				if (q.init_cnt >= RESET_HOLD - 1) begin
					d.rst_n = 1'b1;
					d.cke = 1'b1;
					d.st = ST_RUN;
				end else begin
					d.init_cnt = q.init_cnt + 32'h1;
				end
			end
			ST_RUN: begin
				if (q.ref_due) begin
					if (!q.cke) begin
						d.cmd = CMD_PDX;
						d.cke = 1'b1;
						d.xpdll_cnt = 4'(XPDLL_CYC);
					end else begin
						d.st = ST_PREALL;
					end
				end else if (may_issue) begin
					d.pend = 1'b0;
					d.cmd = q.pcmd;
					d.bank = q.pbank;
					d.bc4 = q.pbc4;
					unique case (q.pcmd)
						CMD_ACT: d.ras_cnt[q.pbank] = 8'(RAS_CYC);
						CMD_WR, CMD_WRA: d.wr_cnt[q.pbank] = wr_total;
						CMD_REF: begin
							d.rfc_cnt = 8'(RFC_CYC);
							d.pden_cnt = 4'(REFPDEN_CK);
							d.ref_total = q.ref_total + 16'h1;
							if (SLOW_CLK) begin
								d.st = ST_POSTPRE;
							end
						end
						CMD_PDE: d.cke = 1'b0;
						CMD_PDX: begin
							d.cke = 1'b1;
							d.xpdll_cnt = 4'(XPDLL_CYC);
						end
						default: begin
						end
					endcase
				end else if (q.pend && ((q.pcmd == CMD_PDX && q.cke) ||
					(q.pcmd == CMD_PDE && !q.cke))) begin
					// Order already in effect; drop it so the port unblocks
					d.pend = 1'b0;
				end
			end
			ST_PREALL: begin
				if (idle_banks && q.xpdll_cnt == 4'h0) begin
					d.cmd = CMD_PREA;
					d.st = ST_REFRESH;
				end
			end
			ST_REFRESH: begin
				if (q.rfc_cnt == 8'h00) begin
					d.cmd = CMD_REF;
					// A fresh expiry in this cycle must not be lost
					d.ref_due = (q.ref_cnt >= ref_period - 12'h001);
					d.rfc_cnt = 8'(RFC_CYC);
					d.pden_cnt = 4'(REFPDEN_CK);
					d.ref_total = q.ref_total + 16'h1;
					d.st = SLOW_CLK ? ST_POSTPRE : ST_RUN;
				end
			end
			ST_POSTPRE: begin
				if (q.rfc_cnt == 8'h00) begin
					d.cmd = CMD_PREA;
					d.st = ST_RUN;
				end
			end
			default: d.st = ST_INIT;
		endcase
		// Register port; a new order while one pends is dropped
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				REG_CTRL: d.ctrl = reg_wdata_i[3:0];
				REG_LAT: begin
					d.lat = reg_wdata_i[11:0];
					d.xpdll_cnt = 4'(XPDLL_CYC);
				end
				REG_CMD: begin
					if (!q.pend) begin
						d.pend = 1'b1;
						d.pcmd = dct_cmd_t'(reg_wdata_i[3:0]);
						d.pbank = reg_wdata_i[CMD_BANK_LO +: 3];
						d.pbc4 = reg_wdata_i[CMD_BC4_BIT];
					end
				end
				default: begin
				end
			endcase
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				REG_CTRL:   d.rdata = {28'h0, q.ctrl};
				REG_LAT:    d.rdata = {20'h0, q.lat};
				REG_CMD:    d.rdata = {24'h0, q.pbc4, q.pbank, q.pcmd};
				REG_STATUS: d.rdata = {q.ref_total, 11'h0, q.xpdll_cnt != 4'h0,
					q.st != ST_RUN, q.cke, q.st != ST_INIT, q.pend};
				default:    d.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '{st: ST_INIT, ctrl: CTRL_RESET, lat: LAT_RESET, pcmd: CMD_NOP,
				cmd: CMD_NOP, default: '0};
		end else begin
			q <= d;
		end
	end

	assign reg_rdata_o = q.rdata;
	assign link.cmd    = q.cmd;
	assign link.bank   = q.bank;
	assign link.bc4    = q.bc4;
	assign link.cke    = q.cke;
	assign link.rst_n  = q.rst_n;
endmodule : dct_ctl
`default_nettype wire

// File: logic/dct_dev.sv
`timescale 1ns/100ps
`default_nettype none
module dct_dev
	import dct_pkg::*;
(
	input  wire logic  sys_clk_i,
	input  wire logic  arst_n_i,
	dct_link_if.dev    link,
	input  wire logic  dll_off_i,
	input  wire logic  bc4_fixed_i,
	input  wire logic [3:0] read_latency_i,
	input  wire logic [3:0] additive_latency_i,
	input  wire logic [3:0] write_latency_i,
	output logic       rd_window_o,
	output logic       auto_pre_o,
	output logic [2:0] auto_pre_bank_o,
	output logic       wr_rec_start_o,
	output logic       violation_o
);
	typedef struct packed {
		logic [7:0][7:0] ras_cnt;
		logic [7:0]      ap_pend;
		logic [7:0]      rfc_cnt;
		logic [4:0]      rd_cnt;
		logic [4:0]      wrs_cnt;
		logic            rd_win;
		logic            ap_pre;
		logic [2:0]      ap_bank;
		logic            wr_rec;
		logic            viol;
	} dct_dev_st_t;

	dct_dev_st_t q, d;
	logic        live;
	logic        found;
	logic [4:0]  rd_lead;
	logic [4:0]  wr_lead;

	assign live    = link.rst_n && link.cke;
	assign rd_lead = 5'(read_latency_i) + 5'(additive_latency_i) - 5'h01;
	assign wr_lead = 5'(write_latency_i) + (bc4_fixed_i ?
		5'(WREC_BC4_CK) : 5'(WREC_BL8_CK));

	always_comb begin
		d = q;
		found = 1'b0;
		d.rd_win = 1'b0;
		d.ap_pre = 1'b0;
		d.wr_rec = 1'b0;
		d.viol = 1'b0;
		for (int b = 0; b < 8; b++) begin
			if (q.ras_cnt[b] != 8'h00) begin
				d.ras_cnt[b] = q.ras_cnt[b] - 8'h01;
			end
		end
		if (q.rfc_cnt != 8'h00) begin
			d.rfc_cnt = q.rfc_cnt - 8'h01;
		end
		if (q.rd_cnt != 5'h00) begin
			d.rd_cnt = q.rd_cnt - 5'h01;
			d.rd_win = (q.rd_cnt == 5'h01);
		end
		if (q.wrs_cnt != 5'h00) begin
			d.wrs_cnt = q.wrs_cnt - 5'h01;
			d.wr_rec = (q.wrs_cnt == 5'h01);
		end
		// Internal precharge, lowest bank first
		for (int b = 0; b < 8; b++) begin
			if (!found && q.ap_pend[b] && q.ras_cnt[b] == 8'h00) begin
				found = 1'b1;
				d.ap_pend[b] = 1'b0;
				d.ap_pre = 1'b1;
				d.ap_bank = 3'(b);
			end
		end
		if (live && link.cmd != CMD_NOP) begin
			// Exact rounded count is accepted
			if (q.rfc_cnt != 8'h00) begin
				d.viol = 1'b1;
			end
			unique case (link.cmd)
				CMD_ACT: begin
					// Zero on the first legal cycle, exact count accepted
					d.ras_cnt[link.bank] = 8'(RAS_CYC - 1);
				end
				CMD_PRE: begin
					if (q.ras_cnt[link.bank] != 8'h00) begin
						d.viol = 1'b1;
					end
				end
				CMD_PREA: begin
					if (q.ras_cnt != '0) begin
						d.viol = 1'b1;
					end
				end
				CMD_RD, CMD_RDA: begin
					if (dll_off_i) begin
						// Registered pulse, so count one short of the lead
						d.rd_cnt = (rd_lead > 5'h01) ? rd_lead - 5'h01 : 5'h00;
						d.rd_win = (rd_lead == 5'h01);
					end
					if (link.cmd == CMD_RDA) begin
						d.ap_pend[link.bank] = 1'b1;
					end
				end
				CMD_WR, CMD_WRA: begin
					d.wrs_cnt = wr_lead - 5'h01;
					d.wr_rec = (wr_lead == 5'h01);
					if (link.cmd == CMD_WRA) begin
						d.ap_pend[link.bank] = 1'b1;
					end
				end
				CMD_REF: begin
					d.rfc_cnt = 8'(RFC_CYC - 1);
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rd_window_o     = q.rd_win;
	assign auto_pre_o      = q.ap_pre;
	assign auto_pre_bank_o = q.ap_bank;
	assign wr_rec_start_o  = q.wr_rec;
	assign violation_o     = q.viol;
endmodule : dct_dev
`default_nettype wire

// File: logic/dct_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dct_link_if;
	import dct_pkg::*;
	dct_cmd_t   cmd;
	logic [2:0] bank;
	logic       bc4;
	logic       cke;
	logic       rst_n;
	modport ctl (output cmd, output bank, output bc4, output cke, output rst_n);
	modport dev (input cmd, input bank, input bc4, input cke, input rst_n);
endinterface : dct_link_if
`default_nettype wire

// File: logic/dct_pkg.sv
`default_nettype none
package dct_pkg;
	localparam int unsigned CLK_PERIOD_PS    = 10000;
	localparam int unsigned ROW_ACTIVE_PS    = 35000;
	localparam int unsigned REFRESH_CYCLE_PS = 160000;
	localparam int unsigned WR_REC_PS        = 15000;
	localparam int unsigned WR_DLL_OFF_CK    = 4;
	localparam int unsigned XPDLL_PS         = 24000;
	localparam int unsigned XPDLL_CK         = 10;
	localparam int unsigned REFPDEN_CK       = 1;
	localparam int unsigned SLOW_CLK_PS      = 40000;
	localparam int unsigned REF_INT_85_PS    = 7812400;
	localparam int unsigned REF_INT_105_PS   = 3906200;
	localparam int unsigned REF_INT_HOT_PS   = 2929650;
	localparam int unsigned RESET_HOLD_PS    = 200000000;
	localparam int unsigned WREC_BL8_CK      = 4;
	localparam int unsigned WREC_BC4_CK      = 2;

	function automatic int unsigned cyc_up(input int unsigned ps);
		int unsigned c;
		c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_up

	function automatic int unsigned cyc_dn(input int unsigned ps);
		int unsigned c;
		c = ps / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_dn

	function automatic int unsigned max2(input int unsigned a, input int unsigned b);
		return (a > b) ? a : b;
	endfunction : max2

	localparam int unsigned RAS_CYC     = cyc_up(ROW_ACTIVE_PS);
	localparam int unsigned RFC_CYC     = cyc_up(REFRESH_CYCLE_PS);
	localparam int unsigned WR_CYC      = cyc_up(WR_REC_PS);
	localparam int unsigned WR_OFF_CYC  = max2(WR_DLL_OFF_CK, cyc_up(WR_REC_PS));
	localparam int unsigned XPDLL_CYC   = max2(XPDLL_CK, cyc_up(XPDLL_PS));
	localparam int unsigned REF_85_CYC  = cyc_dn(REF_INT_85_PS);
	localparam int unsigned REF_105_CYC = cyc_dn(REF_INT_105_PS);
	localparam int unsigned REF_HOT_CYC = cyc_dn(REF_INT_HOT_PS);
	localparam int unsigned RESET_HOLD_CYC = cyc_up(RESET_HOLD_PS);
	localparam bit          SLOW_CLK    = CLK_PERIOD_PS > SLOW_CLK_PS;

	typedef enum logic [3:0] {
		CMD_NOP  = 4'h0,
		CMD_ACT  = 4'h1,
		CMD_RD   = 4'h2,
		CMD_RDA  = 4'h3,
		CMD_WR   = 4'h4,
		CMD_WRA  = 4'h5,
		CMD_PRE  = 4'h6,
		CMD_PREA = 4'h7,
		CMD_REF  = 4'h8,
		CMD_ODT  = 4'h9,
		CMD_PDE  = 4'ha,
		CMD_PDX  = 4'hb
	} dct_cmd_t;

	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_LAT    = 4'h4;
	localparam logic [3:0] REG_CMD    = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hc;
	localparam int unsigned CTRL_DLL_OFF = 0;
	localparam int unsigned CTRL_BC4_FIX = 1;
	localparam int unsigned CTRL_TEMP_LO = 2;
	localparam int unsigned LAT_RL_LO    = 0;
	localparam int unsigned LAT_AL_LO    = 4;
	localparam int unsigned LAT_WL_LO    = 8;
	localparam int unsigned CMD_BANK_LO  = 4;
	localparam int unsigned CMD_BC4_BIT  = 7;
	localparam logic [3:0] CTRL_RESET    = 4'h0;
	localparam logic [11:0] LAT_RESET    = 12'h909;
endpackage : dct_pkg
`default_nettype wire
